/* src/fcad_regs.svh */
`ifndef FCAD_REGS_SVH
`define FCAD_REGS_SVH
// What this block does
// - Select and write low together float result outputs and, when idle, start a conversion
// - Channel address presented during write picks the sampled input
// - Channel address is latched on rising edge of read or write strobe
// - Address high bit is channel_sel_1; codes 00..11 pick inputs 0..3
// - Busy goes low at conversion start and stays low throughout
// - At conversion end, once no read strobe with select is active, busy rises and result outputs become readable unless a write with select coincides
// - Result is a 12-bit word, bit 11 most significant, bit 0 least
// - Read strobe low with select low drives the result onto data outputs once the result is readable
`define FCAD_RESULT_W 12
`define FCAD_CHAN_W 2
`define FCAD_CLKS_PER_CONV 16
`define FCAD_BIT_CNT_W 5
`endif

/* src/fcad_pkg.sv */
package fcad_pkg;
  typedef enum logic [1:0] {
    IDLE,
    CONVERT,
    DELIVER
  } fcad_state_t;
endpackage

/* src/fcad_skid_buf.sv */
`timescale 1ns/1ps
`include "fcad_regs.svh"
// -----------------------------------------
// Two-entry buffer
// -----------------------------------------
module fcad_skid_buf #(
  parameter int W = `FCAD_RESULT_W
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic [1:0]   cnt_q;
  logic [1:0]   cnt_d;
  logic         rd_q;
  logic         rd_d;
  logic         wr_q;
  logic         wr_d;
  logic         push;
  logic         pop;

  assign inReady  = (cnt_q != 2'h2);
  assign outValid = (cnt_q != 2'h0);
  assign outData  = mem_q[rd_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb
  begin
    mem_d = mem_q;
    cnt_d = cnt_q;
    rd_d  = rd_q;
    wr_d  = wr_q;
    if (push)
    begin
      mem_d[wr_q] = inData;
      wr_d        = ~wr_q;
    end
    if (pop)
    begin
      rd_d = ~rd_q;
    end
    if (push && !pop)
    begin
      cnt_d = cnt_q + 2'h1;
    end
    else if (pop && !push)
    begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      cnt_q    <= 2'h0;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
    end
    else
    begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      rd_q  <= rd_d;
      wr_q  <= wr_d;
    end
  end

  a_buf_bound: assert property (@(posedge sys_clk) disable iff (!nrst) cnt_q <= 2'h2)
    else $error("buffer count out of range");
endmodule

/* src/fcad_host_port.sv */
`timescale 1ns/1ps
`include "fcad_regs.svh"
// -----------------------------------------
// Converter control and host port
// -----------------------------------------
module fcad_host_port #(
  parameter int CLKS_PER_CONV = `FCAD_CLKS_PER_CONV
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        deviceSelect_n,
  input  wire logic        convertWrite_n,
  input  wire logic        readStrobe_n,
  input  wire logic        channel_sel_1,
  input  wire logic        channel_sel_0,
  input  wire logic        convClk,
  output logic             busy,
  output logic [3:0]       analogInSel,
  output logic             sampleHold,
  input  wire logic [11:0] sarResult,
  input  wire logic        sarValid,
  output logic [11:0]      resultOut,
  output logic [11:0]      resultOe
);
  // -----------------------------------------
  // Strobe edges and conversion clock
  // -----------------------------------------
  logic                        wrPrev_q;
  logic                        rdPrev_q;
  logic                        clkPrev_q;
  logic                        startReq;
  logic                        strobeRise;
  logic                        clkRise;
  fcad_pkg::fcad_state_t       state_q;
  fcad_pkg::fcad_state_t       state_d;
  logic [`FCAD_CHAN_W-1:0]     chan_q;
  logic [`FCAD_CHAN_W-1:0]     chan_d;
  logic [`FCAD_BIT_CNT_W-1:0]  tick_q;
  logic [`FCAD_BIT_CNT_W-1:0]  tick_d;
  logic                        busy_q;
  logic                        busy_d;
  logic [3:0]                  sel_q;
  logic [3:0]                  sel_d;
  logic                        hold_q;
  logic                        hold_d;
  logic [11:0]                 dout_q;
  logic [11:0]                 dout_d;
  logic                        oe_q;
  logic                        oe_d;
  logic                        ready_q;
  logic                        ready_d;
  logic                        bufOutValid;
  logic [11:0]                 bufOutData;
  logic                        bufPop;
  logic                        readActive;

  assign startReq   = !deviceSelect_n && !convertWrite_n && wrPrev_q;
  assign strobeRise = (convertWrite_n && !wrPrev_q) || (readStrobe_n && !rdPrev_q);
  assign clkRise    = convClk && !clkPrev_q;
  assign readActive = !deviceSelect_n && !readStrobe_n;
  // Word leaves the buffer only when delivered; a held read stalls delivery
  assign bufPop     = bufOutValid && !readActive && (state_q == fcad_pkg::DELIVER);

  fcad_skid_buf #(
    .W (`FCAD_RESULT_W)
  ) u_buf (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .inValid  (sarValid && state_q == fcad_pkg::CONVERT),
    .inReady  (),
    .inData   (sarResult),
    .outValid (bufOutValid),
    .outReady (bufPop),
    .outData  (bufOutData)
  );

  always_comb
  begin
    state_d = state_q;
    chan_d  = chan_q;
    tick_d  = tick_q;
    busy_d  = busy_q;
    sel_d   = sel_q;
    hold_d  = hold_q;
    dout_d  = dout_q;
    ready_d = ready_q;
    if (strobeRise)
    begin
      chan_d = {channel_sel_1, channel_sel_0};
    end
    case (state_q)
      fcad_pkg::IDLE:
      begin
        if (startReq)
        begin
          sel_d   = 4'h1 << {channel_sel_1, channel_sel_0};
          hold_d  = 1'b1;
          busy_d  = 1'b0;
          ready_d = 1'b0;
          tick_d  = '0;
          state_d = fcad_pkg::CONVERT;
        end
      end
      fcad_pkg::CONVERT:
      begin
        if (clkRise)
        begin
          tick_d = tick_q + 5'h1;
          if (tick_q == 5'h0)
          begin
            hold_d = 1'b0;
          end
        end
        if (clkRise && tick_q == 5'(CLKS_PER_CONV - 1))
        begin
          state_d = fcad_pkg::DELIVER;
        end
      end
      fcad_pkg::DELIVER:
      begin
        if (bufPop)
        begin
          dout_d  = bufOutData;
          busy_d  = 1'b1;
          ready_d = 1'b1;
          state_d = fcad_pkg::IDLE;
        end
      end
      default:
      begin
        state_d = fcad_pkg::IDLE;
      end
    endcase
    if (startReq && state_q != fcad_pkg::IDLE)
    begin
      ready_d = 1'b0;
    end
  end

  always_comb
  begin
    oe_d = ready_d && readActive && !startReq;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPrev_q  <= 1'b1;
      rdPrev_q  <= 1'b1;
      clkPrev_q <= 1'b0;
      state_q   <= fcad_pkg::IDLE;
      chan_q    <= '0;
      tick_q    <= '0;
      busy_q    <= 1'b1;
      sel_q     <= 4'h1;
      hold_q    <= 1'b0;
      dout_q    <= 12'h000;
      oe_q      <= 1'b0;
      ready_q   <= 1'b0;
    end
    else
    begin
      wrPrev_q  <= convertWrite_n;
      rdPrev_q  <= readStrobe_n;
      clkPrev_q <= convClk;
      state_q   <= state_d;
      chan_q    <= chan_d;
      tick_q    <= tick_d;
      busy_q    <= busy_d;
      sel_q     <= sel_d;
      hold_q    <= hold_d;
      dout_q    <= dout_d;
      oe_q      <= oe_d;
      ready_q   <= ready_d;
    end
  end

  assign busy        = busy_q;
  assign analogInSel = sel_q;
  assign sampleHold  = hold_q;
  assign resultOut   = dout_q;
  assign resultOe    = {12{oe_q}};

  // -----------------------------------------
  // Checks
  // -----------------------------------------
  // busy low while converting
  a_busy_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_q == fcad_pkg::CONVERT |-> !busy)
    else $error("busy high during conversion");
  a_start_busy: assert property (@(posedge sys_clk) disable iff (!nrst)
    (startReq && state_q == fcad_pkg::IDLE) |=> (!busy && !resultOe[0]))
    else $error("start did not drop busy or float outputs");
  a_float_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
    !$past(readActive) |-> resultOe == 12'h000)
    else $error("outputs driven without read");
  // busy rise comes with data ready
  a_busy_rise: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(busy) |-> ready_q && resultOut == $past(bufOutData))
    else $error("busy rose without result");
  a_sel_onehot: assert property (@(posedge sys_clk) disable iff (!nrst)
    $onehot(analogInSel))
    else $error("input select not one-hot");
  a_chan_pick: assert property (@(posedge sys_clk) disable iff (!nrst)
    (startReq && state_q == fcad_pkg::IDLE) |=>
      analogInSel == (4'h1 << $past({channel_sel_1, channel_sel_0})))
    else $error("wrong channel selected");
  a_addr_latch: assert property (@(posedge sys_clk) disable iff (!nrst)
    strobeRise |=> chan_q == $past({channel_sel_1, channel_sel_0}))
    else $error("address not latched");
  a_read_drive: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ready_q && readActive && !startReq) |=> resultOe == 12'hfff)
    else $error("read did not drive outputs");
endmodule

/* tb/fcad_host_model.sv */
`timescale 1ns/1ps
// -----------------------------------------
// Host bus model
// -----------------------------------------
module fcad_host_model (
  input  wire logic sys_clk,
  output logic      convClk,
  output logic      deviceSelect_n,
  output logic      convertWrite_n,
  output logic      readStrobe_n,
  output logic      channel_sel_1,
  output logic      channel_sel_0
);
  int cyc;
  int half;
  int lastWr;
  initial
  begin
    cyc = 0;
    half = 0;
    lastWr = -1000;
    convClk = 1'b0;
    deviceSelect_n = 1'b1;
    convertWrite_n = 1'b1;
    readStrobe_n = 1'b1;
    {channel_sel_1, channel_sel_0} = 2'h0;
  end
  // clock at 16x sample rate
  // Free running, 40 cycles per period keeps rate under limit
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    half <= (half == 19) ? 0 : half + 1;
    if (half == 19)
      convClk <= ~convClk;
  end
  task automatic wr(input logic [1:0] ch);
    do @(posedge sys_clk);
    while (cyc - lastWr < 625);
    lastWr = cyc;
    deviceSelect_n <= 1'b0;
    convertWrite_n <= 1'b0;
    {channel_sel_1, channel_sel_0} <= ch;
    @(posedge sys_clk);
    deviceSelect_n <= 1'b1;
    convertWrite_n <= 1'b1;
    @(posedge sys_clk);
    // Released lines show inverse, not last value
    {channel_sel_1, channel_sel_0} <= ~ch;
  endtask
  // read strobe with or without select
  task automatic rdOn(input logic sel);
    @(posedge sys_clk);
    deviceSelect_n <= ~sel;
    readStrobe_n <= 1'b0;
  endtask
  task automatic rdOff();
    @(posedge sys_clk);
    deviceSelect_n <= 1'b1;
    readStrobe_n <= 1'b1;
  endtask
endmodule

/* tb/test_four_channel_adc_host_port.sv */
`timescale 1ns/1ps
module test_four_channel_adc_host_port;
  logic        sys_clk;
  logic        nrst;
  logic        convClk;
  logic        deviceSelect_n;
  logic        convertWrite_n;
  logic        readStrobe_n;
  logic        channel_sel_1;
  logic        channel_sel_0;
  logic        busy;
  logic [3:0]  analogInSel;
  logic        sampleHold;
  logic [11:0] sarResult;
  logic        sarValid;
  logic [11:0] resultOut;
  logic [11:0] resultOe;
  int          err_total;
  int          n_compared;
  fcad_host_model u_fcad_host_model (.sys_clk(sys_clk), .convClk(convClk), .deviceSelect_n(deviceSelect_n),
    .convertWrite_n(convertWrite_n), .readStrobe_n(readStrobe_n), .channel_sel_1(channel_sel_1),
    .channel_sel_0(channel_sel_0));
  fcad_host_port #(.CLKS_PER_CONV(16)) u_fcad_host_port (.sys_clk(sys_clk), .nrst(nrst),
    .deviceSelect_n(deviceSelect_n), .convertWrite_n(convertWrite_n), .readStrobe_n(readStrobe_n),
    .channel_sel_1(channel_sel_1), .channel_sel_0(channel_sel_0), .convClk(convClk), .busy(busy),
    .analogInSel(analogInSel), .sampleHold(sampleHold), .sarResult(sarResult), .sarValid(sarValid),
    .resultOut(resultOut), .resultOe(resultOe));
  // -----------------------------------------
  // Checking and closing
  // -----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("Mismatches %0d, comparisons %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic waitBusy(input logic v);
    int k;
    k = 0;
    // Always look off the launching edge
    @(negedge sys_clk);
    while (busy !== v && k < 1000)
    begin
      @(negedge sys_clk);
      k++;
    end
    chk("busy", busy, v);
  endtask
  // -----------------------------------------
  // Scenarios
  // -----------------------------------------
  task automatic tReset();
    @(negedge sys_clk);
    chk("rstOe", resultOe, 12'h0);
    chk("rstBusy", busy, 1'b1);
  endtask
  task automatic tNoSel();
    u_fcad_host_model.rdOn(1'b0);
    repeat (2) @(negedge sys_clk);
    chk("oeNoSel", resultOe, 12'h0);
    u_fcad_host_model.rdOff();
  endtask
  task automatic tConvert(input logic [1:0] ch, input logic [11:0] w);
    u_fcad_host_model.wr(ch);
    waitBusy(1'b0);
    chk("oeStart", resultOe, 12'h0);
    chk("inSel", analogInSel, 4'h1 << ch);
    repeat (3) @(posedge sys_clk);
    sarResult <= w;
    sarValid <= 1'b1;
    @(posedge sys_clk);
    sarValid <= 1'b0;
    sarResult <= ~w;
    // Early read must not leak a stale word
    u_fcad_host_model.rdOn(1'b1);
    repeat (2) @(negedge sys_clk);
    chk("oeEarly", resultOe, 12'h0);
    chk("busyHeld", busy, 1'b0);
    u_fcad_host_model.rdOff();
    waitBusy(1'b1);
    chk("word", resultOut, w);
    chk("holdDone", sampleHold, 1'b0);
    u_fcad_host_model.rdOn(1'b1);
    repeat (2) @(negedge sys_clk);
    chk("oeRead", resultOe, 12'hfff);
    chk("wordRead", resultOut, w);
    u_fcad_host_model.rdOff();
    repeat (2) @(negedge sys_clk);
    chk("oeOff", resultOe, 12'h0);
  endtask
  // Read held across conversion end: word must wait in the buffer, not be lost
  task automatic tStall(input logic [1:0] ch, input logic [11:0] w);
    u_fcad_host_model.wr(ch);
    waitBusy(1'b0);
    @(posedge sys_clk);
    sarResult <= w;
    sarValid <= 1'b1;
    @(posedge sys_clk);
    sarValid <= 1'b0;
    sarResult <= ~w;
    u_fcad_host_model.rdOn(1'b1);
    repeat (700) @(negedge sys_clk);
    chk("busyStall", busy, 1'b0);
    chk("oeStall", resultOe, 12'h0);
    u_fcad_host_model.rdOff();
    waitBusy(1'b1);
    chk("wordStall", resultOut, w);
    chk("holdStall", sampleHold, 1'b0);
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Five conversions need about 3300 cycles
  initial
  begin
    #60000;
    err_total++;
    $display("Watchdog expired");
    end_sim();
  end
  initial
  begin
    err_total = 0;
    n_compared = 0;
    nrst = 1'b0;
    sarResult = 12'h0;
    sarValid = 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    tReset();
    tNoSel();
    tConvert(2'h0, 12'h801);
    tConvert(2'h1, 12'h7fe);
    tConvert(2'h2, 12'ha5c);
    tConvert(2'h3, 12'h3c1);
    tStall(2'h2, 12'h5a3);
    end_sim();
  end
endmodule
